// >>> dsw_pkg.sv
// Package with constants and carriers for the drive status word block.
package dsw_pkg;

  // ==========================================================================
  // Status word bit positions
  // ==========================================================================
  localparam int unsigned SB_CTRL_READY = 0;
  localparam int unsigned SB_DRIVE_READY = 1;
  localparam int unsigned SB_ENABLE = 2;
  localparam int unsigned SB_TRIP = 3;
  localparam int unsigned SB_ERROR = 4;
  localparam int unsigned SB_TRIPLOCK = 6;
  localparam int unsigned SB_WARNING = 7;
  localparam int unsigned SB_AT_REF = 8;
  localparam int unsigned SB_BUS_CTRL = 9;
  localparam int unsigned SB_FREQ_OK = 10;
  localparam int unsigned SB_RUNNING = 11;
  localparam int unsigned SB_AUTO_STOP = 12;
  localparam int unsigned SB_VOLTAGE = 13;
  localparam int unsigned SB_TORQUE = 14;
  localparam int unsigned SB_TIMER = 15;

  // ==========================================================================
  // Widths, scaling and reset values
  // ==========================================================================
  localparam int unsigned WORD_W = 16;
  localparam logic signed [15:0] REF_FULL_SCALE = 16'sh4000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam int unsigned CTRL_RESET_BIT = 7;

  // ==========================================================================
  // Fault state machine
  // ==========================================================================
  typedef enum logic [1:0] {
    DSW_OK = 2'b00,
    DSW_TRIPPED = 2'b01,
    DSW_LOCKED = 2'b10
  } dsw_fault_e;

  // Live conditions from the drive that feed the status word.
  typedef struct packed {
    logic ctrl_ready;
    logic coast_cmd;
    logic start_cmd;
    logic error_no_trip;
    logic warning;
    logic local_stop;
    logic local_ref_sel;
    logic temp_halt;
    logic dc_low;
    logic dc_high;
    logic over_current;
    logic timer_over;
  } dsw_cond_s;

  // Reset requests from the several sources.
  typedef struct packed {
    logic panel_key;
    logic digital_in;
    logic auto_reset_en;
  } dsw_reset_s;

endpackage : dsw_pkg

// >>> dsw_status.sv
// Drive status word assembler with trip, trip-lock and scaled frequency word.
//
// Behaviour
// - Bit 01 set when ready while coast command is still applied.
// - Bit 02 zero when motor released to coast, tripped or halted by overtemperature, else one.
// - Bit 03 one while tripped; cleared only by an accepted reset.
// - Bit 04 one while a non-tripping error is reported.
// - Bit 06 one while tripped and locked.
// - Bit 07 one while any warning is active.
// - Bit 08 one when motor speed equals active reference.
// - Bit 09 one when serial control permitted; serial commands ignored otherwise.
// - Bit 10 one while frequency strictly inside low and high limits.
// - Bit 11 one when start present or output frequency not zero.
// - Bit 12 one while halted by temporary overtemperature and not tripped, auto resume.
// - Bit 13 one when DC link voltage too low or too high.
// - Bit 14 one when motor current exceeds configured limit.
// - Bit 15 one when any thermal timer exceeds full scale.
// - All status bits zero when the bus link is lost.
// - Reference is 16-bit relative; 16384 means full scale.
// - Negative references and frequencies are two's complement.
// - Frequency word uses the same scaling as the reference.
// - Warnings follow their cause and need no reset.
// - Alarm stays tripped until reset after cause removed.
// - Trip-lock ignores resets until power cycle, then resettable; here the power-on reset clears the trip outright.
// - Automatic reset applies only to alarms that are not locked.
// - Serial reset is taken only on rising edge of control bit 07.
// - Bit 00 one when control ready, zero when tripped.
module dsw_status
  import dsw_pkg::*;
#(
  parameter int unsigned FREQ_W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Drive conditions
  input wire dsw_cond_s cond_in,
  input wire dsw_reset_s reset_src_in,
  input wire logic alarm_in,
  input wire logic lock_alarm_in,
  input wire logic link_lost_in,
  // Speed and frequency, relative scaling
  input wire logic signed [FREQ_W-1:0] speed_ref_in,
  input wire logic signed [FREQ_W-1:0] out_freq_in,
  input wire logic signed [FREQ_W-1:0] freq_low_limit_in,
  input wire logic signed [FREQ_W-1:0] freq_high_limit_in,
  // Serial control word
  input wire logic [WORD_W-1:0] ctrl_word_in,
  input wire logic ctrl_word_valid_in,
  // Status outputs
  output logic [WORD_W-1:0] drive_status_word_out,
  output logic signed [FREQ_W-1:0] actual_output_frequency_out,
  output logic bus_ctrl_ok_out,
  output logic signed [FREQ_W-1:0] bus_speed_ref_out
);

  // ==========================================================================
  // Serial control gating and reset edge
  // ==========================================================================
  logic bus_ctrl;
  logic ctrl_reset_q;
  logic serial_reset;
  logic any_reset;
  logic tripped;
  logic locked;

  assign bus_ctrl = !(cond_in.local_stop || cond_in.local_ref_sel);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reset_q <= 1'b0;
    end else begin
      ctrl_reset_q <= ctrl_word_in[CTRL_RESET_BIT];
    end
  end

  // A steady high level must not keep resetting a fresh trip.
  assign serial_reset = bus_ctrl && ctrl_word_valid_in && ctrl_word_in[CTRL_RESET_BIT]
                        && !ctrl_reset_q;

  assign any_reset = serial_reset || reset_src_in.panel_key || reset_src_in.digital_in;

  // Bus reference is passed on only while the serial link may control.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_speed_ref_out <= '0;
    end else if (bus_ctrl && ctrl_word_valid_in) begin
      bus_speed_ref_out <= speed_ref_in;
    end
  end

  // ==========================================================================
  // Fault state
  // ==========================================================================
  // The lock survives any reset request; only the power-on reset
  // (arst_n_in) leaves it, going straight to DSW_OK with no alarm reset needed.
  dsw_fault_e fault_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_q <= DSW_OK;
    end else begin
      unique case (fault_q)
        DSW_OK: begin
          if (lock_alarm_in) begin
            fault_q <= DSW_LOCKED;
          end else if (alarm_in) begin
            fault_q <= DSW_TRIPPED;
          end
        end
        DSW_TRIPPED: begin
          if (lock_alarm_in) begin
            fault_q <= DSW_LOCKED;
          end else if (!alarm_in && (any_reset || reset_src_in.auto_reset_en)) begin
            fault_q <= DSW_OK;
          end
        end
        DSW_LOCKED: begin
          fault_q <= DSW_LOCKED;
        end
        default: begin
          fault_q <= DSW_LOCKED;
        end
      endcase
    end
  end

  assign tripped = (fault_q != DSW_OK);
  assign locked = (fault_q == DSW_LOCKED);

  // ==========================================================================
  // Status word assembly
  // ==========================================================================
  logic [WORD_W-1:0] status_d;
  logic [WORD_W-1:0] status_q;
  logic signed [FREQ_W-1:0] freq_q;

  always_comb begin
    status_d = STATUS_RST;
    status_d[SB_CTRL_READY] = cond_in.ctrl_ready && !tripped;
    status_d[SB_DRIVE_READY] = cond_in.ctrl_ready && !tripped && cond_in.coast_cmd;
    status_d[SB_ENABLE] = !cond_in.coast_cmd && !tripped && !cond_in.temp_halt;
    status_d[SB_TRIP] = tripped;
    status_d[SB_ERROR] = cond_in.error_no_trip;
    status_d[SB_TRIPLOCK] = locked;
    status_d[SB_WARNING] = cond_in.warning;
    status_d[SB_AT_REF] = (out_freq_in == speed_ref_in);
    status_d[SB_BUS_CTRL] = bus_ctrl;
    status_d[SB_FREQ_OK] = (out_freq_in > freq_low_limit_in)
                           && (out_freq_in < freq_high_limit_in);
    status_d[SB_RUNNING] = cond_in.start_cmd || (out_freq_in != '0);
    status_d[SB_AUTO_STOP] = cond_in.temp_halt && !tripped;
    status_d[SB_VOLTAGE] = cond_in.dc_low || cond_in.dc_high;
    status_d[SB_TORQUE] = cond_in.over_current;
    status_d[SB_TIMER] = cond_in.timer_over;
    if (link_lost_in) begin
      status_d = STATUS_RST;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // Frequency is already in reference units, so it is only registered.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      freq_q <= FREQ_W'(FREQ_RST);
    end else begin
      freq_q <= out_freq_in;
    end
  end

  assign drive_status_word_out = status_q;
  assign actual_output_frequency_out = freq_q;
  assign bus_ctrl_ok_out = bus_ctrl;

endmodule : dsw_status

// >>> dsw_status_props.sv
// Concurrent property checker for the drive status word block.
module dsw_status_props
  import dsw_pkg::*;
#(
  parameter int unsigned FREQ_W = 16
) (
  // Clock, reset and inputs
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire dsw_cond_s cond_in,
  input wire logic alarm_in,
  input wire logic link_lost_in,
  input wire logic signed [FREQ_W-1:0] speed_ref_in,
  input wire logic signed [FREQ_W-1:0] out_freq_in,
  input wire logic ctrl_word_valid_in,
  // Outputs
  input wire logic [WORD_W-1:0] drive_status_word_out,
  input wire logic signed [FREQ_W-1:0] actual_output_frequency_out,
  input wire logic bus_ctrl_ok_out,
  input wire logic signed [FREQ_W-1:0] bus_speed_ref_out
);
  default clocking dck @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // The past-reset guard skips the first edge, where outputs still hold reset values.
  property p_warn;
    $past(arst_n_in) && !$past(link_lost_in) |-> drive_status_word_out[SB_WARNING] == $past(cond_in.warning);
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  property p_link;
    $past(link_lost_in) |-> drive_status_word_out == 16'h0000;
  endproperty
  a_link: assert property (p_link) else $error("word not cleared");
  property p_freq;
    $past(arst_n_in) |-> actual_output_frequency_out == $past(out_freq_in);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency word wrong");
  property p_lock_trip;
    drive_status_word_out[SB_TRIPLOCK] |-> drive_status_word_out[SB_TRIP];
  endproperty
  a_lock_trip: assert property (p_lock_trip) else $error("lock without trip");
  property p_lock_hold;
    drive_status_word_out[SB_TRIPLOCK] && !link_lost_in |=> drive_status_word_out[SB_TRIPLOCK];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock released");
  property p_bus_ok;
    bus_ctrl_ok_out == !(cond_in.local_stop || cond_in.local_ref_sel);
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus control flag wrong");
  property p_ref_load;
    bus_ctrl_ok_out && ctrl_word_valid_in |=> bus_speed_ref_out == $past(speed_ref_in);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference not loaded");
  property p_trip;
    alarm_in && !link_lost_in |-> ##[1:3] (drive_status_word_out[SB_TRIP] || $past(link_lost_in));
  endproperty
  a_trip: assert property (p_trip) else $error("trip bit late");
endmodule : dsw_status_props

bind dsw_status dsw_status_props #(.FREQ_W(FREQ_W)) i_dsw_status_props (.clk_in, .arst_n_in, .cond_in,
  .alarm_in, .link_lost_in, .speed_ref_in, .out_freq_in, .ctrl_word_valid_in, .drive_status_word_out,
  .actual_output_frequency_out, .bus_ctrl_ok_out, .bus_speed_ref_out);

// >>> dsw_master.sv
// Serial master model that sends the reset bit of the control word.
module dsw_master
  import dsw_pkg::*;
(
  // Clock and request
  input wire logic clk_in,
  input wire logic pulse_in,
  input wire logic valid_in,
  // Control word
  output logic [WORD_W-1:0] ctrl_word_out,
  output logic valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ctrl_word_out = 16'h0000;
  // Valid is steerable so that the bench can show refused control words.
  assign valid_out = valid_in;
  // The bit follows the request one edge late, so a reset is always a clean rising edge.
  always @(posedge clk_in) ctrl_word_out[CTRL_RESET_BIT] <= #1 pulse_in;
endmodule : dsw_master

// >>> drive_status_fault_word_bench.sv
// Self-checking bench for the drive status word block.
module drive_status_fault_word_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsw_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  dsw_cond_s cond_in = '0;
  dsw_reset_s rst_src = '0;
  logic alarm = 1'b0, lock = 1'b0, lost = 1'b0, pulse = 1'b0;
  logic signed [15:0] sref = 16'sh0000, freq = 16'sh0000;
  logic [15:0] cw, sw, af, br;
  logic valid, ok;
  logic mvalid = 1'b1;
  int fail_count = 0, num_checks = 0;
  int map [7][2] = '{'{8, 4}, '{7, 7}, '{4, 12}, '{3, 13}, '{2, 13}, '{1, 14}, '{0, 15}};
  always #12.5 clk_in = ~clk_in;
  dsw_status i_dsw_status (.clk_in, .arst_n_in, .cond_in, .reset_src_in(rst_src), .alarm_in(alarm),
    .lock_alarm_in(lock), .link_lost_in(lost), .speed_ref_in(sref), .out_freq_in(freq),
    .freq_low_limit_in(16'shFF9C), .freq_high_limit_in(16'sh0064), .ctrl_word_in(cw),
    .ctrl_word_valid_in(valid), .drive_status_word_out(sw), .actual_output_frequency_out(af),
    .bus_ctrl_ok_out(ok), .bus_speed_ref_out(br));
  dsw_master i_dsw_master (.clk_in, .pulse_in(pulse), .valid_in(mvalid), .ctrl_word_out(cw), .valid_out(valid));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    #1ms;
    fail_count++;
    give_verdict();
  end
  initial begin
    tick(20);
    arst_n_in = 1'b1;
    for (int i = 0; i < 7; i++) begin
      cond_in = dsw_cond_s'(12'h800 | (12'h001 << map[i][0]));
      tick(1);
      chk("cond bit", 16'h0001 << map[i][1], sw & (16'h0001 << map[i][1]));
      cond_in = dsw_cond_s'(12'h800);
      tick(1);
      chk("cond clear", 16'h0000, sw & (16'h0001 << map[i][1]));
    end
    cond_in = dsw_cond_s'(12'hC00);
    tick(1);
    chk("coast ready", 16'h0003, sw & 16'h0007);
    cond_in = dsw_cond_s'(12'h800);
    tick(1);
    chk("enabled", 16'h0005, sw & 16'h0007);
    sref = 16'sh4000;
    freq = 16'shC000;
    tick(2);
    chk("freq", 16'hC000, af);
    chk("bus ref", 16'h4000, br);
    chk("off ref", 16'h0000, sw & 16'h0100);
    freq = 16'sh4000;
    tick(2);
    chk("above limit", 16'h0900, sw & 16'h0D00);
    sref = 16'sh0064;
    freq = 16'sh0064;
    tick(2);
    chk("at limit", 16'h0900, sw & 16'h0D00);
    sref = 16'sh0000;
    freq = 16'sh0000;
    tick(2);
    chk("stopped", 16'h0500, sw & 16'h0D00);
    cond_in = dsw_cond_s'(12'h840);
    sref = 16'sh1000;
    tick(1);
    chk("local", 16'h0000, br | (sw & 16'h0200) | 16'(ok));
    cond_in = dsw_cond_s'(12'h800);
    pulse = 1'b1;
    tick(2);
    alarm = 1'b1;
    tick(1);
    alarm = 1'b0;
    tick(3);
    chk("tripped", 16'h0008, sw & 16'h0009);
    mvalid = 1'b0;
    sref = 16'sh2000;
    pulse = 1'b0;
    tick(2);
    pulse = 1'b1;
    tick(4);
    chk("invalid reset", 16'h0008, sw & 16'h0009);
    chk("ref hold", 16'h1000, br);
    mvalid = 1'b1;
    pulse = 1'b0;
    tick(2);
    pulse = 1'b1;
    tick(4);
    chk("serial reset", 16'h0001, sw & 16'h0009);
    lock = 1'b1;
    tick(1);
    lock = 1'b0;
    rst_src = 3'b111;
    pulse = 1'b0;
    tick(2);
    pulse = 1'b1;
    tick(3);
    chk("locked", 16'h0048, sw & 16'h0048);
    arst_n_in = 1'b0;
    tick(1);
    arst_n_in = 1'b1;
    rst_src = 3'b001;
    alarm = 1'b1;
    tick(3);
    chk("power cycle", 16'h0000, sw & 16'h0040);
    alarm = 1'b0;
    tick(4);
    chk("auto reset", 16'h0000, sw & 16'h0008);
    cond_in = dsw_cond_s'(12'h880);
    lost = 1'b1;
    tick(1);
    chk("link lost", 16'h0000, sw);
    give_verdict();
  end
endmodule : drive_status_fault_word_bench
